// File: hw/opm_monitor.sv
`timescale 1ns/1ps
`include "opm_cfg.svh"
module opm_monitor
    import opm_pkg::*;
#(
    parameter int TICK_CYC = `OPM_TICK_CYC,
    parameter logic [15:0] LOW_IDLE_RPM = 16'h0258,
    parameter logic [7:0] FLASH_WARN = 8'h2E,
    parameter logic [7:0] FLASH_DERATE = 8'h2E,
    parameter logic [7:0] FLASH_SHUT = 8'h2E
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire opm_sense_s sense,
    output logic warn_lamp,
    output logic diag_lamp,
    output logic shutdown_cmd,
    output logic [10:0] power_limit,
    output logic [10:0] power_cmd,
    output opm_event_s can_event,
    output logic can_event_valid,
    output logic irq
);
    localparam logic [13:0] DLY_W = 14'(`OPM_WARN_DLY_MS);
    localparam logic [13:0] DLY_D = 14'(`OPM_DERATE_DLY_MS);
    localparam logic [13:0] DLY_S = 14'(`OPM_SHUT_DLY_MS);
    localparam logic [13:0] IDLE_MS = 14'(`OPM_IDLE_RUN_MS);
    localparam logic [10:0] STEP = 11'(`OPM_RAMP_STEP);
    localparam logic [5:0] RAMP_LAST = 6'(`OPM_RAMP_MS - 1);

    function automatic logic [13:0] dly_of(input int i);
        return (i == 0) ? DLY_W : ((i == 1) ? DLY_D : DLY_S);
    endfunction : dly_of

    function automatic logic has_flash(input int i);
        logic [7:0] f;
        f = (i == 0) ? FLASH_WARN : ((i == 1) ? FLASH_DERATE : FLASH_SHUT);
        return f != 8'h00;
    endfunction : has_flash

    function automatic opm_event_s mk_event(input int i);
        opm_event_s e;
        e.spn = `OPM_SPN_OIL;
        e.flash = has_flash(i);
        case (i)
            0: begin
                e.sev = OPM_SEV_WARN;
                e.fmi = `OPM_FMI_WARN;
            end
            1: begin
                e.sev = OPM_SEV_DERATE;
                e.fmi = `OPM_FMI_DERATE;
            end
            default: begin
                e.sev = OPM_SEV_SHUT;
                e.fmi = `OPM_FMI_SHUT;
            end
        endcase
        return e;
    endfunction : mk_event

    // Sensor pins cross in from the outside world
    opm_sense_s sync_a;
    opm_sense_s sync_b;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= sense;
            sync_b <= sync_a;
        end
    end

    logic [11:0] warn_min;
    logic [11:0] crit_min;
    opm_oil_map u_map (
        .clock(clock),
        .rstn(rstn),
        .speed(sync_b.speed),
        .warn_min(warn_min),
        .crit_min(crit_min)
    );

    // 1 ms time base
    logic [23:0] div;
    logic tick;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            div <= 24'h000000;
            tick <= 1'b0;
        end else begin
            tick <= (div == 24'(TICK_CYC - 1));
            if (div == 24'(TICK_CYC - 1)) begin
                div <= 24'h000000;
            end else begin
                div <= div + 24'h000001;
            end
        end
    end

    // Registers
    logic [3:0] ctrl;
    logic [2:0] status;
    logic [2:0] irqen;
    logic [2:0] clr;
    opm_event_s last_event;
    logic wr_en;
    assign wr_en = psel && penable && pready && pwrite;
    assign clr = (wr_en && paddr == `OPM_CLEAR_OFS) ? pwdata[2:0] : 3'h0;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl <= `OPM_CTRL_RST;
            irqen <= 3'h0;
        end else if (wr_en) begin
            if (paddr == `OPM_CTRL_OFS) begin
                ctrl <= pwdata[3:0];
            end
            if (paddr == `OPM_IRQEN_OFS) begin
                irqen <= pwdata[2:0];
            end
        end
    end

    // Engine must run at low idle before any timer counts
    logic [13:0] idle_ms;
    logic idle_ok;
    assign idle_ok = (idle_ms == IDLE_MS);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            idle_ms <= 14'h0000;
        end else if (sync_b.speed < LOW_IDLE_RPM) begin
            idle_ms <= 14'h0000;
        end else if (tick && !idle_ok) begin
            idle_ms <= idle_ms + 14'h0001;
        end
    end

    // Per-level persistence timers
    logic [2:0] below;
    logic [2:0] cond;
    logic [2:0] trip;
    logic [2:0] active;
    logic [13:0] tmr [3];
    assign below[0] = sync_b.oil < warn_min;
    assign below[1] = sync_b.oil < crit_min;
    assign below[2] = sync_b.oil < crit_min;
    assign cond = ctrl[2:0] & below & {3{idle_ok}};

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            trip[i] = cond[i] && (tmr[i] == dly_of(i));
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 3; i++) begin
                tmr[i] <= 14'h0000;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (!cond[i]) begin
                    tmr[i] <= 14'h0000;
                end else if (tick && tmr[i] != dly_of(i)) begin
                    tmr[i] <= tmr[i] + 14'h0001;
                end
            end
        end
    end

    // Shutdown latches until reset; the engine cannot restart itself
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            active <= 3'h0;
        end else begin
            active[1:0] <= trip[1:0];
            active[2] <= active[2] | trip[2];
        end
    end

    // Event queue, one broadcast per cycle, most severe first
    logic [2:0] rise;
    logic [2:0] pend;
    logic [2:0] serve;
    assign rise = trip & ~active;
    always_comb begin
        serve = 3'h0;
        if (pend[2]) begin
            serve = 3'h4;
        end else if (pend[1]) begin
            serve = 3'h2;
        end else if (pend[0]) begin
            serve = 3'h1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pend <= 3'h0;
            can_event_valid <= 1'b0;
            can_event <= '0;
            last_event <= '0;
        end else begin
            pend <= (pend & ~serve) | rise;
            can_event_valid <= |serve;
            if (|serve) begin
                can_event <= mk_event(serve[2] ? 2 : (serve[1] ? 1 : 0));
                last_event <= mk_event(serve[2] ? 2 : (serve[1] ? 1 : 0));
            end
        end
    end

    // Sticky status: a new event wins over a clear in the same cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            status <= 3'h0;
            irq <= 1'b0;
        end else begin
            status <= (status & ~clr) | rise;
            irq <= |(((status & ~clr) | rise) & irqen);
        end
    end

    // Lamps and stop
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            warn_lamp <= 1'b0;
            diag_lamp <= 1'b0;
            shutdown_cmd <= 1'b0;
        end else begin
            warn_lamp <= |(active | trip);
            diag_lamp <= ((active[0] | trip[0]) && has_flash(0))
                || ((active[1] | trip[1]) && has_flash(1))
                || ((active[2] | trip[2]) && has_flash(2));
            shutdown_cmd <= active[2] | trip[2];
        end
    end

    // Derate ramp, 40 ms steps of 0.7 percent
    opm_rmp_e rstate;
    opm_rmp_e next_rstate;
    logic [5:0] step_ms;
    logic step;
    logic [10:0] derate;
    assign step = tick && (step_ms == RAMP_LAST);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            step_ms <= 6'h00;
        end else if (rstate == OPM_RMP_FULL || rstate == OPM_RMP_HELD) begin
            step_ms <= 6'h00;
        end else if (tick) begin
            step_ms <= (step_ms == RAMP_LAST) ? 6'h00 : step_ms + 6'h01;
        end
    end

    always_comb begin
        next_rstate = rstate;
        case (rstate)
            OPM_RMP_FULL: begin
                if (active[1]) begin
                    next_rstate = OPM_RMP_DOWN;
                end
            end
            OPM_RMP_DOWN: begin
                if (!active[1]) begin
                    next_rstate = OPM_RMP_UP;
                end else if (step && derate + STEP >= `OPM_DERATE_MAX) begin
                    next_rstate = OPM_RMP_HELD;
                end
            end
            OPM_RMP_HELD: begin
                if (!active[1]) begin
                    next_rstate = OPM_RMP_UP;
                end
            end
            OPM_RMP_UP: begin
                if (active[1]) begin
                    next_rstate = OPM_RMP_DOWN;
                end else if (step && derate <= STEP) begin
                    next_rstate = OPM_RMP_FULL;
                end
            end
            default: next_rstate = OPM_RMP_FULL;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rstate <= OPM_RMP_FULL;
            derate <= 11'h000;
        end else begin
            rstate <= next_rstate;
            if (step && rstate == OPM_RMP_DOWN) begin
                derate <= (derate + STEP >= `OPM_DERATE_MAX) ?
                    `OPM_DERATE_MAX : derate + STEP;
            end else if (step && rstate == OPM_RMP_UP) begin
                derate <= (derate <= STEP) ? 11'h000 : derate - STEP;
            end
        end
    end

    // Limit and ceiling on demand
    logic [10:0] limit;
    always_comb begin
        if (ctrl[`OPM_CTRL_MODE_BIT]) begin
            limit = `OPM_RATED - {1'b0, derate[10:1]};
        end else begin
            limit = `OPM_RATED - derate;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            power_limit <= `OPM_RATED;
            power_cmd <= 11'h000;
        end else if (active[2] | trip[2]) begin
            power_limit <= 11'h000;
            power_cmd <= 11'h000;
        end else begin
            power_limit <= limit;
            power_cmd <= (sync_b.demand < limit) ?
                sync_b.demand : limit;
        end
    end

    // APB slave: one wait state, unmapped reads zero with error
    logic [31:0] next_prdata;
    logic next_err;
    always_comb begin
        next_prdata = 32'h00000000;
        next_err = 1'b0;
        case (paddr)
            `OPM_CTRL_OFS: next_prdata[3:0] = ctrl;
            `OPM_STATUS_OFS: next_prdata[2:0] = status;
            `OPM_CLEAR_OFS: next_prdata = 32'h00000000;
            `OPM_IRQEN_OFS: next_prdata[2:0] = irqen;
            `OPM_STATE_OFS: begin
                next_prdata[2:0] = active;
                next_prdata[3] = idle_ok;
                next_prdata[5:4] = rstate;
                next_prdata[26:16] = power_limit;
            end
            `OPM_EVENT_OFS: begin
                next_prdata[18:0] = last_event.spn;
                next_prdata[28:24] = last_event.fmi;
                next_prdata[30:29] = last_event.sev;
                next_prdata[31] = last_event.flash;
            end
            default: next_err = 1'b1;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && next_err;
            if (psel && penable && !pready && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end
endmodule : opm_monitor

// File: hw/opm_cfg.svh
`ifndef OPM_CFG_SVH
`define OPM_CFG_SVH
// Register byte offsets
`define OPM_CTRL_OFS 8'h00
`define OPM_STATUS_OFS 8'h04
`define OPM_CLEAR_OFS 8'h08
`define OPM_IRQEN_OFS 8'h0C
`define OPM_STATE_OFS 8'h10
`define OPM_EVENT_OFS 8'h14
// Control fields and reset value
`define OPM_CTRL_RST 4'h3
`define OPM_CTRL_MODE_BIT 3
// Clock and time base
`define OPM_CLK_NS 40
`define OPM_TICK_NS 1000000
`define OPM_TICK_CYC (`OPM_TICK_NS / `OPM_CLK_NS)
// Fixed delays, in seconds and in 1 ms ticks
`define OPM_WARN_DLY_S 8
`define OPM_DERATE_DLY_S 8
`define OPM_SHUT_DLY_S 4
`define OPM_IDLE_RUN_S 10
`define OPM_WARN_DLY_MS (`OPM_WARN_DLY_S * 1000)
`define OPM_DERATE_DLY_MS (`OPM_DERATE_DLY_S * 1000)
`define OPM_SHUT_DLY_MS (`OPM_SHUT_DLY_S * 1000)
`define OPM_IDLE_RUN_MS (`OPM_IDLE_RUN_S * 1000)
// Power in 0.1 percent of rated
`define OPM_RATED 11'd1000
`define OPM_DERATE_MAX 11'd350
`define OPM_RAMP_RATE 175
`define OPM_RAMP_MS 40
`define OPM_RAMP_STEP (`OPM_RAMP_RATE * `OPM_RAMP_MS / 1000)
// Event codes
`define OPM_SPN_OIL 19'd100
`define OPM_FMI_WARN 5'd17
`define OPM_FMI_DERATE 5'd18
`define OPM_FMI_SHUT 5'd1
`endif

// File: hw/opm_pkg.sv
package opm_pkg;
    typedef enum logic [1:0] {
        OPM_SEV_NONE = 2'h0,
        OPM_SEV_WARN = 2'h1,
        OPM_SEV_DERATE = 2'h2,
        OPM_SEV_SHUT = 2'h3
    } opm_sev_e;
    typedef enum logic [1:0] {
        OPM_RMP_FULL = 2'h0,
        OPM_RMP_DOWN = 2'h1,
        OPM_RMP_HELD = 2'h3,
        OPM_RMP_UP = 2'h2
    } opm_rmp_e;
    typedef struct packed {
        opm_sev_e sev;
        logic [18:0] spn;
        logic [4:0] fmi;
        logic flash;
    } opm_event_s;
    typedef struct packed {
        logic [11:0] oil;
        logic [15:0] speed;
        logic [10:0] demand;
    } opm_sense_s;
endpackage : opm_pkg

// File: hw/opm_oil_map.sv
`timescale 1ns/1ps
`include "opm_cfg.svh"
module opm_oil_map
    import opm_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [15:0] speed,
    output logic [11:0] warn_min,
    output logic [11:0] crit_min
);
    // Factory minimum oil pressure in kPa per 256 rpm band
    function automatic logic [11:0] min_at(input logic crit,
                                            input logic [2:0] band);
        logic [11:0] p;
        case (band)
            3'h0: p = 12'h064;
            3'h1: p = 12'h078;
            3'h2: p = 12'h08C;
            3'h3: p = 12'h0A0;
            3'h4: p = 12'h0B4;
            3'h5: p = 12'h0C8;
            3'h6: p = 12'h0D2;
            default: p = 12'h0DC;
        endcase
        // Shared derate and shutdown curve sits lower
        if (crit) begin
            p = p - 12'h028;
        end
        return p;
    endfunction : min_at

    logic [2:0] band;
    assign band = (speed[15:8] > 8'h07) ? 3'h7 : speed[10:8];

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            warn_min <= 12'h000;
            crit_min <= 12'h000;
        end else begin
            warn_min <= min_at(1'b0, band);
            crit_min <= min_at(1'b1, band);
        end
    end
endmodule : opm_oil_map

// File: verif/opm_monitor_assertions.sv
`timescale 1ns/1ps
module opm_chk
    import opm_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic warn_lamp,
    input wire logic diag_lamp,
    input wire logic shutdown_cmd,
    input wire logic [10:0] power_limit,
    input wire logic [10:0] power_cmd,
    input wire opm_event_s can_event,
    input wire logic can_event_valid
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_step;
        !shutdown_cmd && power_limit != $past(power_limit);
    endsequence
    a_apb_wait: assert property (s_setup ##1 s_access |=> pready)
        else $error("pready late after access phase");
    a_err_pulse: assert property (pslverr |-> pready ##1 !pready)
        else $error("pslverr not a single pready pulse");
    a_shut_zero: assert property (
        shutdown_cmd |-> power_limit == 11'h000 && power_cmd == 11'h000)
        else $error("power left on during shutdown");
    a_shut_held: assert property (shutdown_cmd |=> shutdown_cmd)
        else $error("shutdown released");
    a_shut_event: assert property (
        $rose(shutdown_cmd) |=> can_event_valid
        && can_event.sev == OPM_SEV_SHUT)
        else $error("shutdown without its event");
    a_cmd_ceiling: assert property (
        power_cmd <= power_limit || power_cmd <= $past(power_limit))
        else $error("power command above limit");
    a_limit_floor: assert property (
        !shutdown_cmd |-> power_limit >= 11'h28A && power_limit <= 11'h3E8)
        else $error("power limit out of derate range");
    a_ramp_step: assert property (s_step |->
        power_limit + 11'h007 == $past(power_limit)
        || power_limit == $past(power_limit) + 11'h007)
        else $error("ramp step not seven tenths");
    a_ramp_pace: assert property (
        s_step |=> ($stable(power_limit) || shutdown_cmd) [*8])
        else $error("ramp steps too close");
    a_evt_code: assert property (can_event_valid |->
        can_event.spn == 19'h00064 && can_event.fmi ==
        (can_event.sev == OPM_SEV_WARN ? 5'h11 :
        can_event.sev == OPM_SEV_DERATE ? 5'h12 : 5'h01))
        else $error("wrong event code");
    a_evt_sev: assert property (
        can_event_valid |-> can_event.sev != OPM_SEV_NONE)
        else $error("event without severity");
    a_evt_lamp: assert property (can_event_valid |->
        warn_lamp && (diag_lamp || !can_event.flash))
        else $error("lamps off for event");
    a_diag_warn: assert property (diag_lamp |-> warn_lamp)
        else $error("diagnostic lamp alone");
endmodule : opm_chk

bind opm_monitor opm_chk u_chk (.clock, .rstn, .psel, .penable, .pready,
    .pslverr, .warn_lamp, .diag_lamp, .shutdown_cmd, .power_limit,
    .power_cmd, .can_event, .can_event_valid);

// File: verif/opm_engine_model.sv
`timescale 1ns/1ps
module opm_engine_model
    import opm_pkg::*;
(
    input wire logic clock,
    input wire logic [11:0] oil_set,
    input wire logic [15:0] speed_set,
    input wire logic [10:0] demand_set,
    input wire logic shutdown_cmd,
    output opm_sense_s sense
);
    initial sense = '0;
    // Fuel cut stops the engine, so speed falls away after shutdown
    always @(posedge clock) begin
        sense.oil <= oil_set;
        sense.speed <= shutdown_cmd ? 16'h0000 : speed_set;
        sense.demand <= demand_set;
    end
endmodule : opm_engine_model

// File: verif/opm_monitor_bench.sv
`timescale 1ns/1ps
module opm_monitor_bench
    import opm_pkg::*;
;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [11:0] oil = 12'hFFF;
    logic [15:0] speed = 16'h0000;
    logic [10:0] demand = 11'h3E8;
    logic [31:0] prdata, rd;
    logic pready, pslverr, warn_lamp, diag_lamp, shutdown_cmd, irq, err;
    logic can_event_valid;
    logic [10:0] power_limit, power_cmd;
    opm_event_s can_event;
    opm_sense_s sense;
    opm_event_s evq[$];
    int mismatches = 0;
    int checks = 0;
    int cyc = 0;
    int n;

    always #20 clock = ~clock;

    opm_engine_model eng (.clock, .oil_set(oil), .speed_set(speed),
        .demand_set(demand), .shutdown_cmd, .sense);
    // Short tick keeps the 18 s trip path inside the run
    opm_monitor #(.TICK_CYC(2), .FLASH_WARN(8'h00)) DUT (.clock, .rstn,
        .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .sense, .warn_lamp, .diag_lamp, .shutdown_cmd,
        .power_limit, .power_cmd, .can_event, .can_event_valid, .irq);

    task finish_test;
        if (mismatches == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    always @(posedge clock) begin
        cyc++;
        if (can_event_valid === 1'b1)
            evq.push_back(can_event);
        if (cyc == 80000) begin
            mismatches++;
            finish_test();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk1

    function automatic logic [31:0] ev(opm_sev_e s, logic [4:0] f, logic fl);
        opm_event_s e;
        e.sev = s;
        e.spn = 19'h00064;
        e.fmi = f;
        e.flash = fl;
        return {5'h00, e};
    endfunction : ev

    task wait_cyc(input int c);
        repeat (c) @(posedge clock);
    endtask : wait_cyc

    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge clock);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk1(pready, 1'b1);
    endtask : apb

    task t_reset;
        apb(8'h00, 1'b0, 32'h0);
        chk(rd, 32'h3);
        apb(8'h0C, 1'b0, 32'h0);
        chk(rd, 32'h0);
        apb(8'h20, 1'b0, 32'h0);
        chk1(err, 1'b1);
        chk(rd, 32'h0);
        chk({21'h0, power_limit}, 32'h3E8);
        apb(8'h0C, 1'b1, 32'h7);
    endtask : t_reset

    task t_trip;
        @(posedge clock);
        speed <= 16'h03E8;
        oil <= 12'h000;
        wait_cyc(35800);
        chk1(warn_lamp, 1'b0);
        for (n = 0; n < 400 && warn_lamp !== 1'b1; n++) @(posedge clock);
        chk1(warn_lamp, 1'b1);
        wait_cyc(3);
        chk(evq.size(), 32'h2);
        if (evq.size() > 1) begin
            chk({5'h00, evq[0]}, ev(OPM_SEV_DERATE, 5'h12, 1'b1));
            chk({5'h00, evq[1]}, ev(OPM_SEV_WARN, 5'h11, 1'b0));
        end
        chk1(diag_lamp, 1'b1);
        chk1(shutdown_cmd, 1'b0);
        apb(8'h14, 1'b0, 32'h0);
        chk(rd, 32'h31000064);
        apb(8'h04, 1'b0, 32'h0);
        chk(rd, 32'h3);
    endtask : t_trip

    task t_ramp;
        wait_cyc(2000);
        chk1(power_limit >= 11'h332 && power_limit <= 11'h340, 1'b1);
        wait_cyc(2200);
        chk({21'h0, power_limit}, 32'h28A);
        chk({21'h0, power_cmd}, 32'h28A);
        apb(8'h10, 1'b0, 32'h0);
        chk(rd, 32'h028A003B);
        @(posedge clock);
        demand <= 11'h12C;
        wait_cyc(6);
        chk({21'h0, power_cmd}, 32'h12C);
    endtask : t_ramp

    task t_irq;
        chk1(irq, 1'b1);
        apb(8'h0C, 1'b1, 32'h0);
        wait_cyc(2);
        chk1(irq, 1'b0);
        apb(8'h0C, 1'b1, 32'h7);
        wait_cyc(2);
        chk1(irq, 1'b1);
        apb(8'h08, 1'b1, 32'h3);
        wait_cyc(2);
        chk1(irq, 1'b0);
        apb(8'h04, 1'b0, 32'h0);
        chk(rd, 32'h0);
        apb(8'h08, 1'b0, 32'h0);
        chk(rd, 32'h0);
    endtask : t_irq

    task t_shut;
        apb(8'h00, 1'b1, 32'h7);
        wait_cyc(6000);
        oil <= 12'hFFF;
        wait_cyc(10);
        oil <= 12'h000;
        evq.delete();
        wait_cyc(7800);
        chk1(shutdown_cmd, 1'b0);
        for (n = 0; n < 400 && shutdown_cmd !== 1'b1; n++) @(posedge clock);
        chk1(shutdown_cmd, 1'b1);
        chk({21'h0, power_limit}, 32'h0);
        chk({21'h0, power_cmd}, 32'h0);
        wait_cyc(2);
        chk(evq.size(), 32'h1);
        if (evq.size() > 0)
            chk({5'h00, evq[0]}, ev(OPM_SEV_SHUT, 5'h01, 1'b1));
    endtask : t_shut

    initial begin
        wait_cyc(3);
        rstn <= 1'b1;
        t_reset();
        t_trip();
        t_ramp();
        t_irq();
        t_shut();
        finish_test();
    end
endmodule : opm_monitor_bench
